// [inc/rsw_defines.svh]
/*
  constants for the reset source and watchdog block:
  register offsets, field positions, reset values, key codes, times.
  assumes a 32-bit word-aligned register bus.
*/
`ifndef RSW_DEFINES_SVH
`define RSW_DEFINES_SVH

// ==================================
// register byte offsets
`define RSW_OFS_WDT 4'h0
`define RSW_OFS_CAUSE 4'h4
`define RSW_OFS_OSC 4'h8
`define RSW_OFS_CMP 4'hc

// ==================================
// watchdog keys and fields
`define RSW_KEY_RESTART 8'ha5
`define RSW_KEY_DIS1 8'hde
`define RSW_KEY_DIS2 8'had
`define RSW_KEY_LOCK 8'hff
`define RSW_WDT_IV_RST 3'h7
`define RSW_WDT_IV_BIT 7
`define RSW_WDT_RUN_BIT 4
`define RSW_WDT_EXP_BASE 5'h3
`define RSW_DIS_WIN 3'h4

// ==================================
// reset cause bits
`define RSW_B_PIN 0
`define RSW_B_POR 1
`define RSW_B_MCD 2
`define RSW_B_WDT 3
`define RSW_B_SW 4
`define RSW_B_CMP 5

// ==================================
// oscillator control
`define RSW_OSC_RST 8'h04
`define RSW_B_MCDEN 7

// ==================================
// timing and reset values
`define RSW_CLK_MHZ 100
`define RSW_POR_TIME_MS 100
`define RSW_PIN_EXIT_CYC 4'hc
`define RSW_PORT_INIT 8'hff
`define RSW_VECTOR 16'h0000
`define RSW_HTRANS_NSEQ 2'h2

`endif

// [inc/rsw_pkg.sv]
/*
  types for the reset source and watchdog block.
  assumes rsw_defines.svh is visible to the user.
*/
package rsw_pkg;

  // reset sequencer states
  typedef enum logic [2:0] {
    ST_RUN,
    ST_POR_WAIT,
    ST_PIN_HOLD,
    ST_EXIT_DLY,
    ST_CLK_WAIT
  } rsw_state_t;

  // latched bus address phase
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] ofs;
  } rsw_aphase_t;

  // one bit per reset cause
  typedef struct packed {
    logic cmp;
    logic sw;
    logic wdt;
    logic mcd;
    logic por;
    logic pin;
  } rsw_cause_t;

endpackage

// [rtl/rsw_reset_ctrl.sv]
/*
  reset source merger, reset sequencer and watchdog with an
  ahb-lite register slave.
  assumes: rst_n is the supply-on reset of the always-on logic,
  every input is synchronous to clk_sys, the reset pin is
  open drain and pulled up outside, the analog one-shot for clock
  loss reports on clock_loss_in.

  limits: the reset pin is taken as released in the cycle the
  device stops pulling it; a pull-up that rises slowly would be
  read as a fresh press and turn a power-on exit into a pin hold.
  a smaller interval written while the count is already past its
  new end lets the count run on to the wrap of the full width.
  every transfer is answered with no wait state and OKAY; only
  byte 0 of each word is used and the upper bytes read zero.
  a cause write acts on the power-on, software and comparator
  enable bits only; the other bits are read-only flags.
  hsize is not checked: every access is taken as a whole word.

// How it works
// - reset halts core, loads defaults, vector 0x0000
// - data memory untouched; core resets stack pointer
// - port latches all ones, pull-ups stay on
// - supply or forced power-on drives pin low
// - hold until supply good, then 100 ms
// - after reset: 2 MHz osc, watchdog longest
// - six sources can enter reset
// - power-on sets bit 1, others clear it
// - writing bit 1 forces full power-on reset
// - monitor enable input gates supply monitor
// - supply drop resets; recovery like power-on
// - pin reset exits 12 cycles later, bit 0
// - clock loss resets, bit 2, pin idle
// - clock loss detect only when enabled
// - comparator reset when enabled, bit 5
// - 21-bit watchdog overflow resets, pin idle
// - key 0xa5 enables and restarts watchdog
// - 0xde then 0xad within 4 disables
// - 0xff locks out disable until reset
// - timeout is four to three plus interval
// - interval readable, bit 7 zero, resets ones
// - bit 4 reads watchdog running
*/
// Chosen here: the register addresses and the AHB-Lite register port.
`timescale 1ns/1ps
`include "rsw_defines.svh"

module rsw_reset_ctrl
  import rsw_pkg::*;
#(
  parameter int POR_CYC = `RSW_POR_TIME_MS * 1000 * `RSW_CLK_MHZ,
  parameter int WDT_W = 21
) (
  // clock and supply-on reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // reset pin, open drain, active low
  input wire logic rst_pin_n_in,
  output logic rst_pin_n_out,
  output logic rst_pin_n_oe,
  // analog sources
  input wire logic supply_monitor_enable_input,
  input wire logic supply_below_threshold,
  input wire logic comparator_noninv_below_inv,
  input wire logic clock_loss_in,
  input wire logic osc_ready,
  // core side
  output logic core_reset,
  output logic [15:0] core_reset_vector,
  output logic [7:0] port_latch_init,
  output logic port_pullup_en,
  output logic [7:0] osc_ctrl,
  output logic [7:0] cmp_ctrl
);

  // ==================================
  // state
  rsw_state_t st_q, st_d;
  rsw_aphase_t ap_q;
  rsw_cause_t cause_q, cause_d;
  logic [23:0] cnt_q, cnt_d;
  logic [WDT_W-1:0] wdt_q;
  logic wdt_en_q;
  logic lock_q;
  logic [2:0] iv_q;
  logic [2:0] dis_q;
  logic cmp_en_q;
  logic [7:0] osc_q, cmp_q;
  logic [31:0] rd_q;
  logic [15:0] vec_q;
  logic [7:0] port_q;
  logic pull_q;

  // ==================================
  // bus decode
  wire logic addr_ok = hsel && hready && (htrans == `RSW_HTRANS_NSEQ);
  // only the lowest sixteen bytes are mapped; aliases above would hit live keys
  wire logic map_hit = haddr[31:4] == '0;
  wire logic wr_go = ap_q.wr;
  wire logic [7:0] wb = hwdata[7:0];
  wire logic wr_wdt = wr_go && ap_q.ofs == `RSW_OFS_WDT;
  wire logic wr_cause = wr_go && ap_q.ofs == `RSW_OFS_CAUSE;
  wire logic wr_osc = wr_go && ap_q.ofs == `RSW_OFS_OSC;
  wire logic wr_cmp = wr_go && ap_q.ofs == `RSW_OFS_CMP;

  // internal reset of the configuration registers
  wire logic in_rst = !rst_n || st_q != ST_RUN;

  // ==================================
  // watchdog key decode
  wire logic k_restart = wr_wdt && wb == `RSW_KEY_RESTART;
  wire logic k_dis1 = wr_wdt && wb == `RSW_KEY_DIS1;
  wire logic k_dis2 = wr_wdt && wb == `RSW_KEY_DIS2;
  wire logic k_lock = wr_wdt && wb == `RSW_KEY_LOCK;
  wire logic k_iv = wr_wdt && !wb[`RSW_WDT_IV_BIT];
  // second key counts only while the window is open and not locked out
  wire logic dis_ok = k_dis2 && dis_q != 3'h0 && !lock_q;

  // timeout end count 4^(3+iv) - 1
  // the exponent doubles into a shift, so no multiplier is built
  function automatic logic [WDT_W-1:0] wdt_last(input logic [2:0] iv);
    logic [5:0] sh;
    sh = 6'({`RSW_WDT_EXP_BASE + 5'(iv), 1'b0});
    wdt_last = WDT_W'((64'h1 << sh) - 64'h1);
  endfunction

  // last count of the interval; the reset itself lands one edge later
  wire logic wdt_ovf = wdt_en_q && wdt_q == wdt_last(iv_q);

  // ==================================
  // reset sources
  wire logic mon_fail = supply_monitor_enable_input && supply_below_threshold;
  // software force bits act in the data phase of a cause write
  wire logic sw_por = wr_cause && wb[`RSW_B_POR];
  wire logic sw_rst = wr_cause && wb[`RSW_B_SW];
  wire logic pin_low = !rst_pin_n_in;
  wire logic mcd_src = osc_q[`RSW_B_MCDEN] && clock_loss_in;
  wire logic cmp_src = cmp_en_q && comparator_noninv_below_inv;
  wire logic por_src = mon_fail || sw_por;
  wire logic other_src = mcd_src || cmp_src || wdt_ovf || sw_rst;

  // cause for the non power-on, non pin sources, one bit per source active in that cycle
  rsw_cause_t oth_cause;
  assign oth_cause = '{cmp: cmp_src, sw: sw_rst, wdt: wdt_ovf,
                       mcd: mcd_src, por: 1'b0, pin: 1'b0};

  // ==================================
  // reset sequencer next state
  // power-on wait and exit delay share one counter
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    cause_d = cause_q;
    unique case (st_q)
      ST_RUN: begin
        // power-on class wins over the pin, the pin over the rest
        if (por_src) begin
          st_d = ST_POR_WAIT;
          cnt_d = 24'h0;
          cause_d = '{por: 1'b1, default: 1'b0};
        end else if (pin_low) begin
          st_d = ST_PIN_HOLD;
          cause_d = '{pin: 1'b1, default: 1'b0};
        end else if (other_src) begin
          st_d = ST_EXIT_DLY;
          cnt_d = 24'h0;
          cause_d = oth_cause;
        end
      end
      ST_POR_WAIT: begin
        // restart timeout while supply is low
        if (mon_fail) begin
          cnt_d = 24'h0;
        end else if (cnt_q >= 24'(POR_CYC - 1)) begin
          st_d = ST_CLK_WAIT;
        end else begin
          cnt_d = cnt_q + 24'h1;
        end
      end
      ST_PIN_HOLD: begin
        // held here while the line stays low and no power-on class source fires
        if (por_src) begin
          st_d = ST_POR_WAIT;
          cnt_d = 24'h0;
          cause_d = '{por: 1'b1, default: 1'b0};
        end else if (!pin_low) begin
          st_d = ST_EXIT_DLY;
          cnt_d = 24'h0;
        end
      end
      ST_EXIT_DLY: begin
        if (por_src) begin
          st_d = ST_POR_WAIT;
          cnt_d = 24'h0;
          cause_d = '{por: 1'b1, default: 1'b0};
        end else if (pin_low) begin
          // a fresh press restarts the hold and takes over the cause
          st_d = ST_PIN_HOLD;
          cause_d = '{pin: 1'b1, default: 1'b0};
        end else if (cnt_q >= 24'(`RSW_PIN_EXIT_CYC - 4'h1)) begin
          st_d = ST_CLK_WAIT;
        end else begin
          cnt_d = cnt_q + 24'h1;
        end
      end
      ST_CLK_WAIT: begin
        if (por_src) begin
          st_d = ST_POR_WAIT;
          cnt_d = 24'h0;
          cause_d = '{por: 1'b1, default: 1'b0};
        end else if (pin_low) begin
          // a press while the clock settles starts the pin hold over
          st_d = ST_PIN_HOLD;
          cause_d = '{pin: 1'b1, default: 1'b0};
        end else if (osc_ready) begin
          st_d = ST_RUN;
        end
      end
    endcase
  end

  // sequencer registers; supply-on reset is a power-on reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      st_q <= ST_POR_WAIT;
      cnt_q <= 24'h0;
      cause_q <= '{por: 1'b1, default: 1'b0};
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      cause_q <= cause_d;
    end
  end

  // ==================================
  // bus address phase capture
  // the write lands one cycle later, in the data phase, when hwdata stands
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ap_q <= '0;
    end else begin
      ap_q.wr <= addr_ok && hwrite && map_hit;
      ap_q.rd <= addr_ok && !hwrite && map_hit;
      ap_q.ofs <= haddr[3:0];
    end
  end

  // ==================================
  // watchdog control and counter
  // restart and disable keys differ, so one write never carries both
  always_ff @(posedge clk_sys) begin
    if (in_rst) begin
      wdt_en_q <= 1'b1;
      iv_q <= `RSW_WDT_IV_RST;
      lock_q <= 1'b0;
      dis_q <= 3'h0;
      wdt_q <= '0;
    end else begin
      if (k_iv) begin
        iv_q <= wb[2:0];
      end
      if (k_lock) begin
        lock_q <= 1'b1;
      end
      // disable window opens on first key, any other watchdog write closes
      if (k_dis1) begin
        dis_q <= `RSW_DIS_WIN;
      end else if (wr_wdt) begin
        dis_q <= 3'h0;
      end else if (dis_q != 3'h0) begin
        dis_q <= dis_q - 3'h1;
      end
      if (k_restart) begin
        wdt_en_q <= 1'b1;
      end else if (dis_ok) begin
        wdt_en_q <= 1'b0;
      end
      if (k_restart || !wdt_en_q) begin
        wdt_q <= '0;
      end else begin
        wdt_q <= wdt_q + WDT_W'(1);
      end
    end
  end

  // ==================================
  // oscillator, comparator and cause-control registers
  // the oscillator copy also gates the clock-loss source by its enable bit
  always_ff @(posedge clk_sys) begin
    if (in_rst) begin
      osc_q <= `RSW_OSC_RST;
      cmp_q <= 8'h00;
      cmp_en_q <= 1'b0;
    end else begin
      if (wr_osc) begin
        osc_q <= wb;
      end
      if (wr_cmp) begin
        cmp_q <= wb;
      end
      if (wr_cause) begin
        cmp_en_q <= wb[`RSW_B_CMP];
      end
    end
  end

  // ==================================
  // read data mux
  wire logic [7:0] wdt_rd = {3'h0, wdt_en_q, 1'b0, iv_q};
  wire logic [7:0] cause_rd = {2'h0, cause_q};
  logic [31:0] rd_mux;
  always_comb begin
    unique case (haddr[3:0])
      `RSW_OFS_WDT: rd_mux = {24'h0, wdt_rd};
      `RSW_OFS_CAUSE: rd_mux = {24'h0, cause_rd};
      `RSW_OFS_OSC: rd_mux = {24'h0, osc_q};
      `RSW_OFS_CMP: rd_mux = {24'h0, cmp_q};
      default: rd_mux = 32'h0;
    endcase
    // unmapped words read as zero
    if (!map_hit) begin
      rd_mux = 32'h0;
    end
  end

  // read data registered at the address phase
  // so hrdata stands through the whole data phase
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rd_q <= 32'h0;
    end else if (addr_ok && !hwrite) begin
      rd_q <= rd_mux;
    end
  end

  // ==================================
  // core-facing reset values
  // held outside reset so the core sees steady values while it runs;
  // pull-ups stay on in both cases
  always_ff @(posedge clk_sys) begin
    if (in_rst) begin
      vec_q <= `RSW_VECTOR;
      port_q <= `RSW_PORT_INIT;
      pull_q <= 1'b1;
    end else begin
      vec_q <= vec_q;
      port_q <= port_q;
      pull_q <= 1'b1;
    end
  end

  // ==================================
  // outputs
  // no wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_q;
  // pin driven only for power-on class resets
  assign rst_pin_n_out = 1'b0;
  assign rst_pin_n_oe = st_q == ST_POR_WAIT;
  // core halted while sequencer is not running; memories not cleared
  assign core_reset = st_q != ST_RUN;
  assign core_reset_vector = vec_q;
  assign port_latch_init = port_q;
  assign port_pullup_en = pull_q;
  assign osc_ctrl = osc_q;
  assign cmp_ctrl = cmp_q;

endmodule

// [tb/rsw_reset_ctrl_sva.sv]
/*
  checker for the reset source and watchdog block.
  assumes it is bound to rsw_reset_ctrl and sees only its ports.
*/
`timescale 1ns/1ps
module rsw_reset_ctrl_chk #(
  parameter int POR_CYC = 50
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pin and sources
  input wire logic rst_pin_n_in,
  input wire logic rst_pin_n_oe,
  input wire logic rst_pin_n_out,
  input wire logic supply_monitor_enable_input,
  input wire logic supply_below_threshold,
  input wire logic clock_loss_in,
  input wire logic osc_ready,
  // core side
  input wire logic core_reset,
  input wire logic [15:0] core_reset_vector,
  input wire logic [7:0] port_latch_init,
  input wire logic port_pullup_en,
  input wire logic [7:0] osc_ctrl
);
  logic [31:0] por_cnt_q;
  logic [31:0] por_cnt_d;
  logic sup_bad;

  // ==================================
  // helper: cycles of power-on wait with a good supply
  assign sup_bad = supply_monitor_enable_input && supply_below_threshold;
  assign por_cnt_d = (!rst_pin_n_oe || sup_bad) ? 32'h0 : por_cnt_q + 32'h1;
  always_ff @(posedge clk_sys) begin
    por_cnt_q <= rst_n ? por_cnt_d : 32'h0;
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  // ==================================
  // assertions
  init_vals_a: assert property (core_reset |-> core_reset_vector == 16'h0000 &&
    port_latch_init == 8'hff && port_pullup_en) else $error("core defaults wrong in reset");
  exit_dflt_a: assert property ($fell(core_reset) |-> $past(osc_ready) && osc_ctrl == 8'h04)
    else $error("reset exit before clock stable or osc default wrong");
  pin_only_a: assert property (rst_pin_n_oe |-> core_reset) else $error("pin driven outside reset");
  pin_level_a: assert property (rst_pin_n_oe |-> !rst_pin_n_out) else $error("pin driven high");
  por_len_a: assert property ($fell(rst_pin_n_oe) |-> por_cnt_q >= POR_CYC - 2 &&
    por_cnt_q <= POR_CYC + 2) else $error("power-on wait length wrong");
  por_hold_a: assert property (sup_bad && rst_pin_n_oe |=> rst_pin_n_oe)
    else $error("power-on wait ended while supply low");
  brownout_a: assert property (sup_bad && !core_reset |-> ##[1:2] (core_reset && rst_pin_n_oe))
    else $error("supply drop did not reset with pin driven");
  pin_entry_a: assert property (!core_reset && !rst_pin_n_in |-> ##[1:2] core_reset)
    else $error("pin low did not reset");
  pin_exit_a: assert property ($rose(rst_pin_n_in) && !$past(rst_pin_n_oe) |->
    core_reset[*8] ##1 core_reset[*4]) else $error("pin reset left too early");
  clk_loss_a: assert property (!core_reset && clock_loss_in && osc_ctrl[7] |->
    ##[1:2] (core_reset && !rst_pin_n_oe)) else $error("clock loss reset wrong");

  // ==================================
  // covers
  c_por: cover property ($rose(rst_pin_n_oe));
  c_pin: cover property ($rose(rst_pin_n_in) && !$past(rst_pin_n_oe));
  c_mcd: cover property (clock_loss_in && osc_ctrl[7]);
endmodule

bind rsw_reset_ctrl rsw_reset_ctrl_chk #(.POR_CYC(POR_CYC)) i_rsw_reset_ctrl_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .rst_pin_n_in(rst_pin_n_in), .rst_pin_n_oe(rst_pin_n_oe),
  .rst_pin_n_out(rst_pin_n_out), .supply_monitor_enable_input(supply_monitor_enable_input),
  .supply_below_threshold(supply_below_threshold), .clock_loss_in(clock_loss_in), .osc_ready(osc_ready),
  .core_reset(core_reset), .core_reset_vector(core_reset_vector), .port_latch_init(port_latch_init),
  .port_pullup_en(port_pullup_en), .osc_ctrl(osc_ctrl));

// [tb/rsw_pin_drv.sv]
/*
  external reset circuit on the open-drain reset pin.
  assumes a pull-up on the pin and the device's enable as input.
*/
`timescale 1ns/1ps
module rsw_pin_drv (
  // clock
  input wire logic clk_sys,
  // pull requests
  input wire logic press,
  input wire logic dev_oe,
  // resolved pin level
  output logic pin_n
);
  logic hold_q;

  // a press always lasts at least two cycles
  always_ff @(posedge clk_sys) begin
    hold_q <= press;
  end

  // pull-up wins unless some party pulls low
  assign pin_n = !(press || hold_q || dev_oe);
endmodule

// [tb/tb.sv]
/*
  self-checking bench for the reset source and watchdog block.
  assumes the design, the pin model and the bound checker.
*/
`timescale 1ns/1ps
`include "rsw_defines.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end

module tb;
  localparam int POR_N = 50;
  localparam logic [31:0] A_WDT = 32'(`RSW_OFS_WDT);
  localparam logic [31:0] A_CAU = 32'(`RSW_OFS_CAUSE);
  localparam logic [31:0] A_OSC = 32'(`RSW_OFS_OSC);
  localparam logic [31:0] A_CMP = 32'(`RSW_OFS_CMP);
  logic clk_sys = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = '0, hwdata = '0, e_v;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic press = 1'b0, mon_en = 1'b1, sup_low = 1'b0, cmp_low = 1'b0, clk_loss = 1'b0, osc_rdy = 1'b1;
  logic rd_dp = 1'b0, hreadyout, pin_n, pin_oe, core_reset;
  logic [7:0] cmp_ctrl;
  logic [31:0] hrdata;
  logic [31:0] exp_q[$];
  int err_count = 0, check_count = 0, n;

  always #5 clk_sys = ~clk_sys;

  // ==================================
  // design and pin partner
  rsw_reset_ctrl #(.POR_CYC(POR_N)) i_rsw_reset_ctrl (
    .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .rst_pin_n_in(pin_n), .rst_pin_n_out(), .rst_pin_n_oe(pin_oe), .supply_monitor_enable_input(mon_en),
    .supply_below_threshold(sup_low), .comparator_noninv_below_inv(cmp_low), .clock_loss_in(clk_loss),
    .osc_ready(osc_rdy), .core_reset(core_reset), .core_reset_vector(), .port_latch_init(),
    .port_pullup_en(), .osc_ctrl(), .cmp_ctrl(cmp_ctrl));
  rsw_pin_drv i_rsw_pin_drv (.clk_sys(clk_sys), .press(press), .dev_oe(pin_oe), .pin_n(pin_n));

  // ==================================
  // tasks
  task automatic finish_test();
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // one single transfer: address phase, then data phase
  task automatic bus(input logic [31:0] a, input logic wr, input logic [7:0] d);
    int k;
    k = 0;
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= `RSW_HTRANS_NSEQ;
    do begin @(posedge clk_sys); k++; end while (!hreadyout && k < 50);
    htrans <= 2'h0;
    hwdata <= {24'($urandom()), d};
    do begin @(posedge clk_sys); k++; end while (!hreadyout && k < 100);
    if (k >= 100) begin err_count++; finish_test(); end
  endtask

  task automatic wr(input logic [31:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 8'h00);
  endtask

  // bounded wait for a core reset level
  task automatic wait_cr(input logic lvl);
    n = 0;
    while (core_reset !== lvl && n < 300) begin @(posedge clk_sys); n++; end
    if (n >= 300) begin err_count++; finish_test(); end
  endtask

  // read data compared against the oldest note
  always @(posedge clk_sys) begin
    if (rd_dp) begin
      e_v = exp_q.pop_front();
      `CHK("hrdata", e_v, hrdata);
    end
    rd_dp <= hsel && htrans == `RSW_HTRANS_NSEQ && !hwrite && hreadyout;
  end

  // ==================================
  // main sequence
  initial begin
    void'($urandom(32'h6fcd));
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    wait_cr(1'b0);
    rd(A_CAU, 32'h02);
    rd(A_WDT, 32'h17);
    rd(A_OSC, 32'h04);
    rd(32'h10, 32'h0);
    wr(32'h10, 8'h00);
    wr(A_WDT, `RSW_KEY_DIS1);
    wr(A_WDT, `RSW_KEY_DIS2);
    rd(A_WDT, 32'h07);
    wr(A_WDT, `RSW_KEY_RESTART);
    rd(A_WDT, 32'h17);
    wr(A_WDT, `RSW_KEY_DIS1);
    wr(A_WDT, 8'h05);
    wr(A_WDT, `RSW_KEY_DIS2);
    rd(A_WDT, 32'h15);
    wr(A_WDT, `RSW_KEY_DIS1);
    repeat (3) @(posedge clk_sys);
    wr(A_WDT, `RSW_KEY_DIS2);
    rd(A_WDT, 32'h15);
    wr(A_WDT, `RSW_KEY_DIS1);
    wr(A_WDT, `RSW_KEY_DIS2);
    wr(A_WDT, `RSW_KEY_LOCK);
    rd(A_WDT, 32'h05);
    wr(A_WDT, `RSW_KEY_RESTART);
    wr(A_WDT, `RSW_KEY_DIS1);
    wr(A_WDT, `RSW_KEY_DIS2);
    rd(A_WDT, 32'h15);
    wr(A_WDT, 8'h00);
    wr(A_WDT, `RSW_KEY_RESTART);
    wait_cr(1'b1);
    `CHK("wdt_time", 1'b1, n >= 64 && n <= 66);
    wait_cr(1'b0);
    rd(A_CAU, 32'h08);
    rd(A_WDT, 32'h17);
    wr(A_WDT, `RSW_KEY_DIS1);
    wr(A_WDT, `RSW_KEY_DIS2);
    rd(A_WDT, 32'h07);
    press <= 1'b1;
    repeat (1 + $urandom() % 4) @(posedge clk_sys);
    press <= 1'b0;
    wait_cr(1'b1);
    wait_cr(1'b0);
    rd(A_CAU, 32'h01);
    osc_rdy <= 1'b0;
    wr(A_CAU, 8'h10);
    wait_cr(1'b1);
    repeat (20) @(posedge clk_sys);
    `CHK("osc_wait", 1'b1, core_reset);
    osc_rdy <= 1'b1;
    wait_cr(1'b0);
    rd(A_CAU, 32'h10);
    wr(A_CAU, 8'h02);
    wait_cr(1'b1);
    repeat (2) @(posedge clk_sys);
    `CHK("pin_drive", 1'b1, pin_oe);
    wait_cr(1'b0);
    rd(A_CAU, 32'h02);
    cmp_low <= 1'b1;
    clk_loss <= 1'b1;
    mon_en <= 1'b0;
    sup_low <= 1'b1;
    repeat (5) @(posedge clk_sys);
    `CHK("gated", 1'b0, core_reset);
    cmp_low <= 1'b0;
    clk_loss <= 1'b0;
    sup_low <= 1'b0;
    mon_en <= 1'b1;
    wr(A_CMP, 8'h80);
    rd(A_CMP, 32'h80);
    `CHK("cmp_ctrl", 8'h80, cmp_ctrl);
    wr(A_CAU, 8'h20);
    cmp_low <= 1'b1;
    wait_cr(1'b1);
    cmp_low <= 1'b0;
    wait_cr(1'b0);
    rd(A_CAU, 32'h20);
    wr(A_OSC, 8'h84);
    clk_loss <= 1'b1;
    wait_cr(1'b1);
    clk_loss <= 1'b0;
    wait_cr(1'b0);
    rd(A_CAU, 32'h04);
    sup_low <= 1'b1;
    wait_cr(1'b1);
    repeat (10) @(posedge clk_sys);
    sup_low <= 1'b0;
    wait_cr(1'b0);
    rd(A_CAU, 32'h02);
    finish_test();
  end
endmodule
